/* File: shared/absb_pkg.sv */
// Package: register map, field layout and timing constants of the buffer status and event bank
package absb_pkg;
   // Geometry
   localparam int unsigned ABSB_FIFO_CNT = 30;         // Outbound queues
   localparam int unsigned ABSB_PAIR_CNT = 15;         // Head or tail pair registers
   localparam int unsigned ABSB_PTR_W = 9;             // Pointer width
   localparam int unsigned ABSB_IDX_W = 5;             // Queue index width
   localparam int unsigned ABSB_DEPTH_W = 10;          // Free space width
   localparam int unsigned ABSB_USED_W = 14;           // Occupancy accumulator width
   localparam int unsigned ABSB_TRACE_W = 30;          // Trace write address width
   localparam int unsigned ABSB_TRK_W = 3;             // Burst tracker width
   localparam int unsigned ABSB_ADDR_W = 12;           // APB address width

   // Evaluation pass
   localparam logic [4:0] ABSB_PASS_LAST = 5'h1F;      // 32 cycles per pass
   localparam logic [9:0] ABSB_MEM_SIZE = 10'h200;     // Shared memory size
   localparam logic [9:0] ABSB_DEPTH_RST = 10'h000;    // Free space after reset

   // Field positions
   localparam int unsigned ABSB_RDIDX_LSB = 27;        // Lowest unread index
   localparam int unsigned ABSB_RDPTR_LSB = 16;        // Lowest unread pointer
   localparam int unsigned ABSB_WRPTR_LSB = 0;         // Shared write pointer
   localparam int unsigned ABSB_PAIR_ODD_LSB = 16;     // Odd queue in a pair
   localparam int unsigned ABSB_PAIR_EVEN_LSB = 0;     // Even queue in a pair
   localparam int unsigned ABSB_RUN_BIT = 0;           // Run indicator
   localparam int unsigned ABSB_HFN_BIT = 28;          // Hyper-frame number mismatch
   localparam int unsigned ABSB_TYPE_BIT = 27;         // Illegal header type
   localparam int unsigned ABSB_ADR_BIT = 26;          // Illegal header address
   localparam int unsigned ABSB_SYNC_BIT = 25;         // Sync character mismatch
   localparam logic [31:0] ABSB_RAW_MASK = 32'h1E00_0000; // Implemented raw flag bits

   // Register offsets (byte addresses)
   localparam logic [11:0] ABSB_PTR_STS_OFS = 12'h000;
   localparam logic [11:0] ABSB_DEPTH_OFS = 12'h004;
   localparam logic [11:0] ABSB_NE_OFS = 12'h008;
   localparam logic [11:0] ABSB_TRACE_OFS = 12'h00C;
   localparam logic [11:0] ABSB_RUN_OFS = 12'h010;
   localparam logic [11:0] ABSB_RAW_OFS = 12'h014;
   localparam logic [11:0] ABSB_MSKD_OFS = 12'h018;
   localparam logic [11:0] ABSB_ENA_OFS = 12'h01C;
   localparam logic [11:0] ABSB_TRK_OFS = 12'h020;
   localparam logic [11:0] ABSB_HEAD_OFS = 12'h040;    // Pair k at +4k
   localparam logic [11:0] ABSB_TAIL_OFS = 12'h080;    // Pair k at +4k
   localparam logic [11:0] ABSB_PAIR_SPAN = 12'h03C;   // Block end offset from base; the last pair (14) sits at +0x038
endpackage

/* File: src/absb_status_bank.sv */
// Outbound buffer status bank with link raw error flags behind an APB slave
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module absb_status_bank
   import absb_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ABSB_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Buffer state from the data buffer
   input wire logic [ABSB_FIFO_CNT-1:0][ABSB_PTR_W-1:0] fifo_head_i,
   input wire logic [ABSB_FIFO_CNT-1:0][ABSB_PTR_W-1:0] fifo_tail_i,
   input wire logic [ABSB_PTR_W-1:0] shared_write_pointer_i,
   input wire logic [ABSB_TRACE_W-1:0] trace_wr_addr_i,
   // Exception handler events
   input wire logic run_start_i,
   input wire logic interface_event_line_i,
   input wire logic hyperframe_number_mismatch_i,
   input wire logic illegal_header_type_i,
   input wire logic illegal_header_address_i,
   input wire logic sync_character_mismatch_i,
   // Link 0 encoder burst tracker events
   input wire logic burst_stored_i,
   input wire logic burst_consumed_i,
   input wire logic burst_eight_word_i,
   // Status outputs
   output logic interface_running_o,
   output logic tracker_error_o
);

   // Registered copies of the buffer state
   logic [ABSB_FIFO_CNT-1:0][ABSB_PTR_W-1:0] head_ff;    // Head pointers
   logic [ABSB_FIFO_CNT-1:0][ABSB_PTR_W-1:0] tail_ff;    // Tail pointers
   logic [ABSB_FIFO_CNT-1:0] queue_nonempty_flags_ff;     // Not-empty flags
   logic [ABSB_PTR_W-1:0] shared_write_pointer_ff;        // Write pointer
   logic [ABSB_TRACE_W-1:0] trace_addr_ff;                // Trace next address
   // Evaluation pass state
   logic [4:0] pass_cnt_ff;                               // Slot under evaluation
   logic [ABSB_IDX_W-1:0] acc_idx_ff;                     // Best index so far
   logic [ABSB_PTR_W-1:0] acc_ptr_ff;                     // Best pointer so far
   logic acc_found_ff;                                    // Any non-empty queue seen
   logic [ABSB_USED_W-1:0] acc_used_ff;                   // Occupied words so far
   logic [ABSB_IDX_W-1:0] lowest_unread_fifo_index_ff;    // Published index
   logic [ABSB_PTR_W-1:0] lowest_unread_pointer_ff;       // Published pointer
   logic [ABSB_DEPTH_W-1:0] free_space_count_ff;          // Published free space
   // Event and tracker state
   logic run_ff;                                          // Run indicator
   logic [31:0] raw_ff;                                   // Link 0 raw flags A
   logic [31:0] ena_ff;                                   // Masked view enables
   logic [ABSB_TRK_W-1:0] encoder_burst_tracker_link0_ff; // Burst tracker
   logic trk_err_ff;                                      // Tracker wrap pulse
   // APB state
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;

   // Bus decode
   logic wr_done;          // Write takes effect this edge
   logic setup;            // Setup phase seen
   logic [31:0] rd_word;   // Read mux
   logic rd_hit;           // Address is mapped
   logic [11:0] pair_ofs;  // Offset within a pair block
   logic [3:0] pair_idx;   // Pair number
   logic [9:0] pair_lo;    // Even queue slot
   logic [9:0] pair_hi;    // Odd queue slot

   assign setup = psel_i & ~penable_i;
   assign wr_done = psel_i & penable_i & pready_ff & pwrite_i;

   // Capture buffer state; inputs come from logic on this clock
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         head_ff <= '0;
         tail_ff <= '0;
         shared_write_pointer_ff <= '0;
         trace_addr_ff <= '0;
      end else begin
         head_ff <= fifo_head_i;
         tail_ff <= fifo_tail_i;
         shared_write_pointer_ff <= shared_write_pointer_i;
         trace_addr_ff <= trace_wr_addr_i;
      end
   end

   // Not-empty flags, one per queue
   genvar g;
   generate
      for (g = 0; g < ABSB_FIFO_CNT; g++) begin : g_ne
         always_ff @(posedge core_clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               queue_nonempty_flags_ff[g] <= 1'b0;
            end else begin
               queue_nonempty_flags_ff[g] <= (fifo_head_i[g] != fifo_tail_i[g]);
            end
         end
      end
   endgenerate

   // Slot under evaluation; slots 30 and 31 are idle padding of the pass
   logic slot_live;
   logic [ABSB_IDX_W-1:0] slot;
   logic [ABSB_PTR_W-1:0] slot_head;
   logic [ABSB_PTR_W-1:0] slot_used;
   logic [ABSB_USED_W-1:0] used_sum;
   logic better;
   always_comb begin
      slot = pass_cnt_ff;
      slot_live = (pass_cnt_ff < ABSB_IDX_W'(ABSB_FIFO_CNT));
      slot_head = '0;
      slot_used = '0;
      if (slot_live) begin
         slot_head = head_ff[slot];
         slot_used = tail_ff[slot] - head_ff[slot];       // Modulo 512 occupancy
      end
      better = slot_live && queue_nonempty_flags_ff[slot] &&
               (!acc_found_ff || (slot_head < acc_ptr_ff));
      used_sum = acc_used_ff + ABSB_USED_W'(slot_used);
   end

   // Serial evaluation pass: one queue per cycle keeps the comparator small,
   // at the price of values up to two passes stale
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pass_cnt_ff <= '0;
         acc_idx_ff <= '0;
         acc_ptr_ff <= '0;
         acc_found_ff <= 1'b0;
         acc_used_ff <= '0;
      end else begin
         pass_cnt_ff <= pass_cnt_ff + 5'h01;
         if (pass_cnt_ff == ABSB_PASS_LAST) begin
            // Start a fresh pass
            acc_idx_ff <= '0;
            acc_ptr_ff <= '0;
            acc_found_ff <= 1'b0;
            acc_used_ff <= '0;
         end else begin
            if (better) begin
               acc_idx_ff <= slot;
               acc_ptr_ff <= slot_head;
               acc_found_ff <= 1'b1;
            end
            acc_used_ff <= used_sum;
         end
      end
   end

   // Publish results at the end of each pass
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lowest_unread_fifo_index_ff <= '0;
         lowest_unread_pointer_ff <= '0;
         free_space_count_ff <= ABSB_DEPTH_RST;
      end else if (pass_cnt_ff == ABSB_PASS_LAST) begin
         if (acc_found_ff) begin
            lowest_unread_fifo_index_ff <= acc_idx_ff;
            lowest_unread_pointer_ff <= acc_ptr_ff;
         end else begin
            // Nothing unread: the write pointer is the lowest unread place
            lowest_unread_fifo_index_ff <= '0;
            lowest_unread_pointer_ff <= shared_write_pointer_ff;
         end
         if (acc_used_ff >= ABSB_USED_W'(ABSB_MEM_SIZE)) begin
            free_space_count_ff <= '0;
         end else begin
            free_space_count_ff <= ABSB_MEM_SIZE - acc_used_ff[ABSB_DEPTH_W-1:0];
         end
      end
   end

   // Run indicator; an event pulse wins over a start in the same cycle
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         run_ff <= 1'b0;
      end else if (interface_event_line_i) begin
         run_ff <= 1'b0;
      end else if (run_start_i) begin
         run_ff <= 1'b1;
      end
   end

   // Raw flags: hardware set wins over a clear in the same cycle
   logic [31:0] hw_set;
   logic [31:0] sw_set;
   logic [31:0] sw_clr;
   always_comb begin
      hw_set = '0;
      hw_set[ABSB_HFN_BIT] = hyperframe_number_mismatch_i;
      hw_set[ABSB_TYPE_BIT] = illegal_header_type_i;
      hw_set[ABSB_ADR_BIT] = illegal_header_address_i;
      hw_set[ABSB_SYNC_BIT] = sync_character_mismatch_i;
      sw_set = '0;
      sw_clr = '0;
      if (wr_done && (paddr_i == ABSB_RAW_OFS)) begin
         sw_set = pwdata_i & ABSB_RAW_MASK;
      end
      if (wr_done && (paddr_i == ABSB_MSKD_OFS)) begin
         sw_clr = pwdata_i & ABSB_RAW_MASK;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         raw_ff <= '0;
      end else begin
         raw_ff <= ((raw_ff & ~sw_clr) | sw_set | hw_set) & ABSB_RAW_MASK;
      end
   end

   // Enables for the masked view
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ena_ff <= '0;
      end else if (wr_done && (paddr_i == ABSB_ENA_OFS)) begin
         ena_ff <= pwdata_i & ABSB_RAW_MASK;
      end
   end

   // Encoder burst tracker: eight-word bursts move it by two
   logic [ABSB_TRK_W:0] trk_step;
   logic [ABSB_TRK_W:0] trk_up;
   logic [ABSB_TRK_W:0] trk_dn;
   logic trk_wrap;
   always_comb begin
      trk_step = burst_eight_word_i ? 4'h2 : 4'h1;
      trk_up = {1'b0, encoder_burst_tracker_link0_ff} + trk_step;
      trk_dn = {1'b0, encoder_burst_tracker_link0_ff} - trk_step;
      trk_wrap = 1'b0;
      if (burst_stored_i && !burst_consumed_i) begin
         trk_wrap = trk_up[ABSB_TRK_W];                   // Above 7
      end else if (burst_consumed_i && !burst_stored_i) begin
         trk_wrap = trk_dn[ABSB_TRK_W];                   // Below 0
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         encoder_burst_tracker_link0_ff <= '0;
         trk_err_ff <= 1'b0;
      end else begin
         // Store and consume together cancel out
         if (burst_stored_i && !burst_consumed_i) begin
            encoder_burst_tracker_link0_ff <= trk_up[ABSB_TRK_W-1:0];
         end else if (burst_consumed_i && !burst_stored_i) begin
            encoder_burst_tracker_link0_ff <= trk_dn[ABSB_TRK_W-1:0];
         end
         trk_err_ff <= trk_wrap;
      end
   end

   // Read mux; reads touch no state
   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      pair_ofs = '0;
      pair_idx = '0;
      pair_lo = '0;
      pair_hi = '0;
      if ((paddr_i >= ABSB_HEAD_OFS) && (paddr_i <= ABSB_TAIL_OFS + ABSB_PAIR_SPAN) &&
          (paddr_i[1:0] == 2'b00)) begin
         pair_ofs = (paddr_i >= ABSB_TAIL_OFS) ? (paddr_i - ABSB_TAIL_OFS) : (paddr_i - ABSB_HEAD_OFS);
         pair_idx = pair_ofs[5:2];
         pair_lo = {5'h00, pair_idx, 1'b0};
         pair_hi = {5'h00, pair_idx, 1'b1};
         if ((paddr_i > ABSB_HEAD_OFS + ABSB_PAIR_SPAN) && (paddr_i < ABSB_TAIL_OFS)) begin
            rd_hit = 1'b0;                                // Gap between blocks
         end else if (paddr_i >= ABSB_TAIL_OFS) begin
            rd_word[ABSB_PAIR_EVEN_LSB +: ABSB_PTR_W] = tail_ff[pair_lo[4:0]];
            rd_word[ABSB_PAIR_ODD_LSB +: ABSB_PTR_W] = tail_ff[pair_hi[4:0]];
         end else begin
            rd_word[ABSB_PAIR_EVEN_LSB +: ABSB_PTR_W] = head_ff[pair_lo[4:0]];
            rd_word[ABSB_PAIR_ODD_LSB +: ABSB_PTR_W] = head_ff[pair_hi[4:0]];
         end
      end else begin
         case (paddr_i)
            ABSB_PTR_STS_OFS: begin
               rd_word[ABSB_RDIDX_LSB +: ABSB_IDX_W] = lowest_unread_fifo_index_ff;
               rd_word[ABSB_RDPTR_LSB +: ABSB_PTR_W] = lowest_unread_pointer_ff;
               rd_word[ABSB_WRPTR_LSB +: ABSB_PTR_W] = shared_write_pointer_ff;
            end
            ABSB_DEPTH_OFS: rd_word[ABSB_DEPTH_W-1:0] = free_space_count_ff;
            ABSB_NE_OFS: rd_word[ABSB_FIFO_CNT-1:0] = queue_nonempty_flags_ff;
            ABSB_TRACE_OFS: rd_word[ABSB_TRACE_W-1:0] = trace_addr_ff;
            ABSB_RUN_OFS: rd_word[ABSB_RUN_BIT] = run_ff;
            ABSB_RAW_OFS: rd_word = raw_ff;
            ABSB_MSKD_OFS: rd_word = raw_ff & ena_ff;
            ABSB_ENA_OFS: rd_word = ena_ff;
            ABSB_TRK_OFS: rd_word[ABSB_TRK_W-1:0] = encoder_burst_tracker_link0_ff;
            default: rd_hit = 1'b0;
         endcase
      end
   end

   // APB: no wait state; ready is registered from the setup phase so every answer comes from a flip-flop.
   // Writes to status-only offsets complete with no effect.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= '0;
      end else begin
         pready_ff <= setup;
         if (setup) begin
            pslverr_ff <= ~rd_hit;
            prdata_ff <= (pwrite_i || !rd_hit) ? 32'h0000_0000 : rd_word;
         end else begin
            pslverr_ff <= 1'b0;
         end
      end
   end

   // Outputs straight from flip-flops
   assign prdata_o = prdata_ff;
   assign pready_o = pready_ff;
   assign pslverr_o = pslverr_ff;
   assign interface_running_o = run_ff;
   assign tracker_error_o = trk_err_ff;

endmodule
`default_nettype wire

/* File: testbench/absb_checker.sv */
// Concurrent checks on the ports of the buffer status and event bank
`timescale 1ns/1ps
`default_nettype none
module absb_checker
   import absb_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // APB side
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ABSB_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Events and status
   input wire logic run_start_i,
   input wire logic interface_event_line_i,
   input wire logic burst_stored_i,
   input wire logic burst_consumed_i,
   input wire logic interface_running_o,
   input wire logic tracker_error_o
);
   logic [5:0] since_rst_ff; // Edges since reset release, saturating
   logic [5:0] nxt_since_rst; // Next count
   logic depth_rd; // Read answer from the free depth register
   assign nxt_since_rst = (since_rst_ff == 6'h3F) ? since_rst_ff : since_rst_ff + 6'h01;
   assign depth_rd = pready_o && !pwrite_i && (paddr_i == ABSB_DEPTH_OFS);
   // Count edges so the early free depth window can be judged
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         since_rst_ff <= 6'h00;
      end else begin
         since_rst_ff <= nxt_since_rst;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o) else $error("ready late");
   a_ready_one_cycle: assert property (pready_o |=> !pready_o) else $error("ready held");
   a_err_misaligned: assert property (pready_o && paddr_i[1:0] != 2'b00 |-> pslverr_o) else $error("no error");
   a_err_needs_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
   a_run_event_clears: assert property (interface_event_line_i |=> !interface_running_o) else $error("run kept");
   a_run_start_sets: assert property (run_start_i && !interface_event_line_i |=> interface_running_o)
      else $error("run not set");
   a_run_bit_holds: assert property (!run_start_i && !interface_event_line_i |=> $stable(interface_running_o))
      else $error("run moved");
   a_depth_early_zero: assert property (depth_rd && since_rst_ff < 6'd28 |-> prdata_o == 32'h0000_0000)
      else $error("depth not zero early");
   a_depth_in_range: assert property (depth_rd |-> prdata_o[31:10] == 22'h0 && prdata_o[9:0] <= 10'h200)
      else $error("depth out of range");
   a_ptr_reserved_zero: assert property (pready_o && !pwrite_i && paddr_i == ABSB_PTR_STS_OFS
      |-> prdata_o[26:25] == 2'b00 && prdata_o[15:9] == 7'h00) else $error("reserved bits set");
   a_trk_err_cause: assert property (tracker_error_o |-> $past(burst_stored_i) || $past(burst_consumed_i)
      || $past(burst_stored_i, 2) || $past(burst_consumed_i, 2)) else $error("tracker error uncaused");
   c_refused: cover property (pready_o && pslverr_o);
   c_wrap: cover property (tracker_error_o);
   c_run_drop: cover property ($fell(interface_running_o));
endmodule
`default_nettype wire

/* File: testbench/absb_status_bank_tb_top.sv */
// Self-checking bench for the buffer status and event bank
`timescale 1ns/1ps
`default_nettype none
module absb_status_bank_tb_top
   import absb_pkg::*;
;
   typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} absb_exp_t;
   logic core_clk_i = 1'b0; // Core clock
   logic nrst_i = 1'b0; // Reset, low active
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0; // APB control
   logic [ABSB_ADDR_W-1:0] paddr_i = '0; // APB address
   logic [31:0] pwdata_i = '0; // APB write data
   logic [31:0] prdata_o; // APB read data
   logic pready_o, pslverr_o, interface_running_o, tracker_error_o; // Design outputs
   logic [ABSB_FIFO_CNT-1:0][ABSB_PTR_W-1:0] head_q = '0, tail_q = '0; // Queue pointers
   logic [8:0] wp = '0; // Shared write pointer
   logic [29:0] trace = '0; // Trace address
   logic [8:0] ctl = '0; // Event pulses: run, event, four flags, stored, consumed, eight
   logic [31:0] seed = 32'h6f80_b8e7; // Generator state
   absb_exp_t notes[$]; // Expected answers, oldest first
   int failures = 0, comparisons = 0, trk_errs = 0;
   always #4 core_clk_i = ~core_clk_i;
   absb_status_bank u_absb_status_bank (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .fifo_head_i(head_q), .fifo_tail_i(tail_q),
      .shared_write_pointer_i(wp), .trace_wr_addr_i(trace), .run_start_i(ctl[0]), .interface_event_line_i(ctl[1]),
      .hyperframe_number_mismatch_i(ctl[2]), .illegal_header_type_i(ctl[3]), .illegal_header_address_i(ctl[4]),
      .sync_character_mismatch_i(ctl[5]), .burst_stored_i(ctl[6]), .burst_consumed_i(ctl[7]),
      .burst_eight_word_i(ctl[8]), .interface_running_o(interface_running_o), .tracker_error_o(tracker_error_o));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error: %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; the answer is judged by the monitor below
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
      input logic [31:0] m, input logic err);
      notes.push_back('{exp & m, m, err});
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      // Wait for the answer however long it takes; only the watchdog ends a hang
      do begin
         @(posedge core_clk_i);
      end while (pready_o !== 1'b1);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000, exp, 32'hFFFF_FFFF, 1'b0);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 32'h0000_0000, 32'h0000_0000, 1'b0);
   endtask
   task automatic pulse(input logic [8:0] m);
      @(posedge core_clk_i);
      ctl <= m;
      @(posedge core_clk_i);
      ctl <= '0;
   endtask
   // Load random pointers, let two passes run, then read every buffer status word
   task automatic round(input int empties);
      logic [29:0][8:0] h, t;
      logic [29:0] ne;
      logic [31:0] r, w;
      int idx, lo, used;
      idx = 0;
      lo = 512;
      used = 0;
      for (int k = 0; k < 30; k++) begin
         r = xs();
         h[k] = r[8:0];
         t[k] = r[8:0] + ((k % empties == 0) ? 9'd0 : {6'd0, r[11:9]});
         ne[k] = (h[k] != t[k]);
         used += int'(9'(t[k] - h[k]));
         if (ne[k] && int'(h[k]) < lo) begin
            lo = h[k];
            idx = k;
         end
      end
      r = xs();
      if (lo == 512) lo = r[8:0];
      @(posedge core_clk_i);
      head_q <= h;
      tail_q <= t;
      wp <= r[8:0];
      trace <= r[31:2];
      repeat (70) @(posedge core_clk_i);
      w = {idx[4:0], 2'b00, lo[8:0], 7'h00, r[8:0]};
      rd(ABSB_PTR_STS_OFS, w);
      wr(ABSB_PTR_STS_OFS, xs());
      rd(ABSB_PTR_STS_OFS, w);
      rd(ABSB_DEPTH_OFS, (used > 512) ? 32'h0 : 32'(512 - used));
      rd(ABSB_NE_OFS, {2'b00, ne});
      rd(ABSB_TRACE_OFS, {2'b00, r[31:2]});
      for (int p = 0; p < 15; p++) begin
         rd(ABSB_HEAD_OFS + 12'(4 * p), {7'h00, h[2 * p + 1], 7'h00, h[2 * p]});
         rd(ABSB_TAIL_OFS + 12'(4 * p), {7'h00, t[2 * p + 1], 7'h00, t[2 * p]});
      end
   endtask
   task automatic results();
      if (notes.size() != 0) failures++;
      $display("Counts: comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Judge each APB answer against the oldest note
   always @(posedge core_clk_i) begin
      absb_exp_t e;
      if (psel_i && penable_i && pready_o === 1'b1 && notes.size() > 0) begin
         e = notes.pop_front();
         comparisons++;
         if (pslverr_o !== e.err || (prdata_o & e.mask) !== e.data) begin
            failures++;
            $display("Error: reg %h expected %h err %b seen %h err %b", paddr_i, e.data, e.err, prdata_o, pslverr_o);
         end
      end
      if (tracker_error_o === 1'b1) trk_errs++;
   end
   // Watchdog, far beyond the roughly 700 cycles the tests need
   initial begin
      #160000;
      failures++;
      $display("Error: watchdog expired");
      results();
   end
   initial begin
      logic [31:0] exp;
      repeat (16) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      rd(ABSB_DEPTH_OFS, 32'h0000_0000);
      repeat (40) @(posedge core_clk_i);
      rd(ABSB_DEPTH_OFS, 32'h0000_0200);
      $display("Test free depth after reset done");
      round(1);
      round(3);
      round(2);
      $display("Test pointer status rounds done");
      chk("run idle", 32'h0, {31'h0, interface_running_o});
      pulse(9'h001);
      rd(ABSB_RUN_OFS, 32'h0000_0001);
      chk("run out", 32'h1, {31'h0, interface_running_o});
      pulse(9'h003);
      rd(ABSB_RUN_OFS, 32'h0000_0000);
      $display("Test run indicator done");
      exp = 32'h0;
      for (int b = 0; b < 4; b++) begin
         pulse(9'h004 << b);
         exp = exp | (32'h1000_0000 >> b);
         rd(ABSB_RAW_OFS, exp);
      end
      wr(ABSB_ENA_OFS, 32'hFFFF_FFFF);
      rd(ABSB_ENA_OFS, 32'h1E00_0000);
      rd(ABSB_MSKD_OFS, 32'h1E00_0000);
      wr(ABSB_MSKD_OFS, 32'h0200_0000);
      rd(ABSB_RAW_OFS, 32'h1C00_0000);
      wr(ABSB_RAW_OFS, 32'hFFFF_FFFF);
      rd(ABSB_RAW_OFS, 32'h1E00_0000);
      wr(ABSB_MSKD_OFS, 32'hFFFF_FFFF);
      rd(ABSB_RAW_OFS, 32'h0000_0000);
      $display("Test raw flags done");
      rd(ABSB_TRK_OFS, 32'h0000_0000);
      repeat (3) pulse(9'h040);
      rd(ABSB_TRK_OFS, 32'h0000_0003);
      repeat (3) pulse(9'h140);
      rd(ABSB_TRK_OFS, 32'h0000_0001);
      chk("tracker wraps", 32'd1, 32'(trk_errs));
      pulse(9'h0C0);
      pulse(9'h080);
      pulse(9'h080);
      rd(ABSB_TRK_OFS, 32'h0000_0007);
      chk("tracker wraps", 32'd2, 32'(trk_errs));
      $display("Test burst tracker done");
      xfer(1'b0, 12'h024, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
      xfer(1'b1, 12'h016, 32'hFFFF_FFFF, 32'h0, 32'h0, 1'b1);
      xfer(1'b1, 12'h0FC, 32'hFFFF_FFFF, 32'h0, 32'h0, 1'b1);
      rd(ABSB_RAW_OFS, 32'h0000_0000);
      $display("Test refused accesses done");
      repeat (4) @(posedge core_clk_i);
      results();
   end
endmodule
bind absb_status_bank absb_checker u_absb_checker (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .run_start_i(run_start_i), .interface_event_line_i(interface_event_line_i),
   .burst_stored_i(burst_stored_i), .burst_consumed_i(burst_consumed_i),
   .interface_running_o(interface_running_o), .tracker_error_o(tracker_error_o));
`default_nettype wire
